// ===== bench/pnct_assertions.sv
// checker for strap capture and reference pin muxing
`default_nettype none
module pnct_checker (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic [4:0] modeStrap,
    input wire logic       refClockOutStrap,
    input wire logic       funcRefClock,
    input wire logic       funcMdioOe_n,
    input wire logic       refClockTestOut,
    input wire logic       refClockTestOe_n,
    input wire logic       mdioOe_n,
    input wire logic       testMode,
    input wire logic [4:0] funcStatusLightOut,
    input wire logic [4:0] funcStatusLightOe_n,
    input wire logic [3:0] funcRxdOut,
    input wire logic       funcRxCtlOut,
    input wire logic       funcRxcOut,
    input wire logic       funcIntOut,
    input wire logic       funcIntOe_n,
    input wire logic       funcMdioOut,
    input wire logic [4:0] statusLightOe_n,
    input wire logic [3:0] rxdOe_n,
    input wire logic       rxCtlOe_n,
    input wire logic       rxcOe_n,
    input wire logic       intOe_n,
    input wire logic [4:0] statusLightOut,
    input wire logic [3:0] rxdOut,
    input wire logic       rxCtlOut,
    input wire logic       rxcOut,
    input wire logic       intOut,
    input wire logic       mdioOut
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_mode_enter: assert property (reset_n && !$past(reset_n) |=>
        testMode == ($past(modeStrap) == 5'h04)) else $error("bad mode");
    a_mode_hold: assert property ($past(reset_n) |=> $stable(testMode))
        else $error("mode moved");
    a_test_entry: assert property ($rose(testMode) |->
        $past(reset_n, 1) && !$past(reset_n, 2)) else $error("late entry");
    a_oe_strap: assert property (reset_n && !$past(reset_n) |=>
        refClockTestOe_n == !$past(refClockOutStrap)) else $error("bad oe");
    a_oe_hold: assert property ($past(reset_n) |=>
        $stable(refClockTestOe_n)) else $error("oe moved");
    a_func_out: assert property (!testMode |->
        refClockTestOut == funcRefClock) else $error("clock not passed");
    a_pins_quiet: assert property (testMode |-> mdioOe_n)
        else $error("pin driven in test");
    a_test_float: assert property (testMode |-> &statusLightOe_n
        && &rxdOe_n && rxCtlOe_n && rxcOe_n && intOe_n)
        else $error("chain pin driven in test");
    a_func_drive: assert property (!testMode |->
        statusLightOe_n == funcStatusLightOe_n && rxdOe_n == 4'h0
        && !rxCtlOe_n && !rxcOe_n && intOe_n == funcIntOe_n)
        else $error("functional enables lost");
    a_data_pass: assert property (statusLightOut == funcStatusLightOut
        && rxdOut == funcRxdOut && rxCtlOut == funcRxCtlOut
        && rxcOut == funcRxcOut && intOut == funcIntOut
        && mdioOut == funcMdioOut) else $error("pin data lost");
    a_func_oe: assert property (!testMode |->
        mdioOe_n == funcMdioOe_n) else $error("func enable lost");
    cover property ($rose(testMode));
    cover property (testMode && $changed(refClockTestOut));
    cover property (!testMode && !refClockTestOe_n);
endmodule // pnct_checker
bind pnct_pin_nand_chain_test pnct_checker u_chk (.clock, .reset_n,
    .modeStrap, .refClockOutStrap, .funcRefClock, .funcMdioOe_n,
    .refClockTestOut, .refClockTestOe_n, .mdioOe_n, .testMode,
    .funcStatusLightOut, .funcStatusLightOe_n, .funcRxdOut, .funcRxCtlOut,
    .funcRxcOut, .funcIntOut, .funcIntOe_n, .funcMdioOut, .statusLightOe_n,
    .rxdOe_n, .rxCtlOe_n, .rxcOe_n, .intOe_n, .statusLightOut, .rxdOut,
    .rxCtlOut, .rxcOut, .intOut, .mdioOut);
`default_nettype wire

// ===== bench/pnct_tester.sv
// board tester model: one pin toggled, lower low, higher high
`default_nettype none
module pnct_tester (
    input  wire logic [4:0]  pick,
    input  wire logic        level,
    output var  logic [0:19] chain
);
    always_comb begin
        chain = 20'hfffff >> pick;
        chain[pick] = level;
    end
endmodule // pnct_tester
`default_nettype wire

// ===== bench/testbench.sv
// bench for the pin nand chain test block
`default_nettype none
`define CHK(n, e, s) begin totalChecks++; if ((e) !== (s)) begin \
    errCount++; $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0, reset_n = 1'b0, strap = 1'b0, level = 1'b0;
    logic        exp, out, oe_n, tm;
    logic [4:0]  mode = 5'h00, pick = 5'h00;
    logic [0:19] c;
    logic [31:0] r = 32'h87d7dcf0;
    int          errCount = 0, totalChecks = 0;
    logic        q[$];
    pnct_tester u_tester (.pick(pick), .level(level), .chain(c));
    pnct_pin_nand_chain_test u_dut (.clock(clock), .reset_n(reset_n),
        .modeStrap(mode), .refClockOutStrap(strap), .statusLightIn(c[0:4]),
        .txdIn({c[8], c[7], c[6], c[5]}), .txcIn(c[9]), .txCtlIn(c[10]),
        .rxdIn(c[11:14]), .rxCtlIn(c[15]), .rxcIn(c[16]), .intIn(c[17]),
        .mdcIn(c[18]), .mdioIn(c[19]), .funcRefClock(r[0]),
        .funcStatusLightOut(r[5:1]), .funcStatusLightOe_n(r[10:6]),
        .funcRxdOut(r[14:11]), .funcRxCtlOut(r[15]), .funcRxcOut(r[16]),
        .funcIntOut(r[17]), .funcIntOe_n(r[18]), .funcMdioOut(r[19]),
        .funcMdioOe_n(r[20]), .refClockTestOut(out), .refClockTestOe_n(oe_n),
        .statusLightOe_n(), .rxdOe_n(), .rxCtlOe_n(), .rxcOe_n(), .intOe_n(),
        .mdioOe_n(), .statusLightOut(), .rxdOut(), .rxCtlOut(), .rxcOut(),
        .intOut(), .mdioOut(), .testMode(tm));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic finalReport;
        if (errCount == 0 && totalChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        forever #20 clock = ~clock;
    end
    always @(negedge clock) begin
        if (q.size() > 0) begin
            exp = q.pop_front();
            `CHK("chain out", exp, out)
        end
    end
    initial begin
        for (int m = 0; m < 4; m++) begin
            @(posedge clock);
            reset_n <= 1'b0;
            mode <= 5'h04 ^ {m[1] & m[0], 3'h0, m[1]};
            strap <= (m != 1);
            repeat (2) @(posedge clock);
            reset_n <= 1'b1;
            repeat (2) @(negedge clock);
            `CHK("testMode", m < 2, tm)
            `CHK("refClockTestOe_n", m == 1, oe_n)
            for (int k = 0; k < 40; k++) begin
                @(posedge clock);
                pick <= 5'(k / 2);
                level <= k[0];
                r <= lfsr(r);
                mode <= r[4:0];
                if (tm === 1'b1) q.push_back(k[1] ~^ k[0]);
            end
        end
        repeat (2) @(negedge clock);
        finalReport();
    end
    initial begin
        #100000;
        errCount++;
        finalReport();
    end
endmodule // testbench
`default_nettype wire

// ===== inc/pnct_map.vh
// constants for the pin nand chain test block
`ifndef PNCT_MAP_VH
`define PNCT_MAP_VH
`define PNCT_MODE_W         5
`define PNCT_MODE_TEST      5'h04
`define PNCT_MODE_RST       5'h00
`define PNCT_RST_TEST       1'b0
`define PNCT_RST_CLKEN      1'b0
`define PNCT_FUNC_DRIVE     1'b0
`define PNCT_CHAIN_LEN      20
`define PNCT_POS_LIGHT5     0
`define PNCT_POS_LIGHT1     4
`define PNCT_POS_TXD0       5
`define PNCT_POS_TXD3       8
`define PNCT_POS_TXC        9
`define PNCT_POS_TXCTL      10
`define PNCT_POS_RXD3       11
`define PNCT_POS_RXD0       14
`define PNCT_POS_RXCTL      15
`define PNCT_POS_RXC        16
`define PNCT_POS_INT        17
`define PNCT_POS_MDC        18
`define PNCT_POS_MDIO       19
`endif

// ===== src/pnct_nand_chain.v
// combinational nand chain with final inversion
`default_nettype none
`include "pnct_map.vh"
module pnct_nand_chain (
    input  wire [`PNCT_CHAIN_LEN-1:0] chainIn,
    output wire                       chainOut
);
    reg [`PNCT_CHAIN_LEN:0] stage;
    integer i;
    always @* begin
        stage[0] = 1'b1; // (R3)
        for (i = 0; i < `PNCT_CHAIN_LEN; i = i + 1) begin
            stage[i+1] = ~(chainIn[i] & stage[i]); // (R2)
        end
    end
    assign chainOut = ~stage[`PNCT_CHAIN_LEN]; // (R4)
endmodule // pnct_nand_chain
`default_nettype wire

// ===== src/pnct_pin_nand_chain_test.v
// pin nand chain test: strap capture, chain and pin muxing
//
// Functional notes
// (R1) test mode only when sampled five mode straps equal 00100
// (R2) chain of two-input nands, each pin nanded with previous stage
// (R3) first stage nands first pin with constant one
// (R4) last stage output inverted once more before the output pin
// (R5) lights 5..1, txd0..3, txc, txctl, rxd3..0, rxctl, rxc, int, mdc, mdio
// (R6) tester toggles one pin, lower ranked low, higher ranked high
// (R7) even positions appear inverted at the output pin
// (R8) result driven on ref clock pin only when its strap enables output
// (R9) any other strap code keeps chain idle, pins behave normally
`default_nettype none
`include "pnct_map.vh"
module pnct_pin_nand_chain_test (
    input  wire                    clock,
    input  wire                    reset_n,
    input  wire [`PNCT_MODE_W-1:0] modeStrap,
    input  wire                    refClockOutStrap,
    input  wire [4:0]              statusLightIn,
    input  wire [3:0]              txdIn,
    input  wire                    txcIn,
    input  wire                    txCtlIn,
    input  wire [3:0]              rxdIn,
    input  wire                    rxCtlIn,
    input  wire                    rxcIn,
    input  wire                    intIn,
    input  wire                    mdcIn,
    input  wire                    mdioIn,
    input  wire                    funcRefClock,
    input  wire [4:0]              funcStatusLightOut,
    input  wire [4:0]              funcStatusLightOe_n,
    input  wire [3:0]              funcRxdOut,
    input  wire                    funcRxCtlOut,
    input  wire                    funcRxcOut,
    input  wire                    funcIntOut,
    input  wire                    funcIntOe_n,
    input  wire                    funcMdioOut,
    input  wire                    funcMdioOe_n,
    output wire                    refClockTestOut,
    output wire                    refClockTestOe_n,
    output wire [4:0]              statusLightOe_n,
    output wire [3:0]              rxdOe_n,
    output wire                    rxCtlOe_n,
    output wire                    rxcOe_n,
    output wire                    intOe_n,
    output wire                    mdioOe_n,
    output wire [4:0]              statusLightOut,
    output wire [3:0]              rxdOut,
    output wire                    rxCtlOut,
    output wire                    rxcOut,
    output wire                    intOut,
    output wire                    mdioOut,
    output wire                    testMode
);
    // capture states
    localparam [1:0] ST_SAMPLE = 2'b00;
    localparam [1:0] ST_NORMAL = 2'b01;
    localparam [1:0] ST_TEST   = 2'b10;

    reg  [1:0]                 state_ff;
    reg  [1:0]                 nxt_state;
    reg                        testMode_ff;
    reg                        nxt_testMode;
    reg                        clkOutEn_ff;
    reg                        nxt_clkOutEn;
    wire                       strapHit;
    wire [`PNCT_CHAIN_LEN-1:0] chainIn;
    wire                       chainOut;

    // strap code compare
    function strapMatch;
        input [`PNCT_MODE_W-1:0] straps;
        input [`PNCT_MODE_W-1:0] code;
        begin
            strapMatch = (straps == code);
        end
    endfunction

    // one active low enable: floats in test
    function oeSel;
        input inTest;
        input funcOe_n;
        begin
            oeSel = inTest | funcOe_n;
        end
    endfunction

    assign strapHit = strapMatch(modeStrap, `PNCT_MODE_TEST); // (R1)

    // one strap sample after each reset release
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_SAMPLE: begin
                if (strapHit) begin
                    nxt_state = ST_TEST; // (R1)
                end else begin
                    nxt_state = ST_NORMAL; // (R9)
                end
            end
            ST_NORMAL: begin
                nxt_state = ST_NORMAL;
            end
            ST_TEST: begin
                nxt_state = ST_TEST;
            end
            default: begin
                nxt_state = ST_NORMAL;
            end
        endcase
    end

    // straps taken only in the sample state, then held
    always @* begin
        nxt_testMode = testMode_ff;
        nxt_clkOutEn = clkOutEn_ff;
        case (state_ff)
            ST_SAMPLE: begin
                nxt_testMode = strapHit; // (R1)
                nxt_clkOutEn = refClockOutStrap; // (R8)
            end
            ST_NORMAL: begin
                nxt_testMode = 1'b0; // (R9)
            end
            ST_TEST: begin
                nxt_testMode = 1'b1;
            end
            default: begin
                nxt_testMode = 1'b0;
            end
        endcase
    end

    // state and captured straps, cleared by reset
    always @(posedge clock) begin
        if (!reset_n) begin
            state_ff    <= ST_SAMPLE;
            testMode_ff <= `PNCT_RST_TEST;
            clkOutEn_ff <= `PNCT_RST_CLKEN;
        end else begin
            state_ff    <= nxt_state;
            testMode_ff <= nxt_testMode;
            clkOutEn_ff <= nxt_clkOutEn;
        end
    end

    // chain inputs ranked first stage to last
    assign chainIn[`PNCT_POS_LIGHT5]   = statusLightIn[4]; // (R5)
    assign chainIn[`PNCT_POS_LIGHT5+1] = statusLightIn[3]; // (R5)
    assign chainIn[`PNCT_POS_LIGHT5+2] = statusLightIn[2]; // (R5)
    assign chainIn[`PNCT_POS_LIGHT1-1] = statusLightIn[1]; // (R5)
    assign chainIn[`PNCT_POS_LIGHT1]   = statusLightIn[0]; // (R5)
    assign chainIn[`PNCT_POS_TXD0]     = txdIn[0]; // (R5)
    assign chainIn[`PNCT_POS_TXD0+1]   = txdIn[1]; // (R5)
    assign chainIn[`PNCT_POS_TXD3-1]   = txdIn[2]; // (R5)
    assign chainIn[`PNCT_POS_TXD3]     = txdIn[3]; // (R5)
    assign chainIn[`PNCT_POS_TXC]      = txcIn; // (R5)
    assign chainIn[`PNCT_POS_TXCTL]    = txCtlIn; // (R5)
    assign chainIn[`PNCT_POS_RXD3]     = rxdIn[3]; // (R5)
    assign chainIn[`PNCT_POS_RXD3+1]   = rxdIn[2]; // (R5)
    assign chainIn[`PNCT_POS_RXD0-1]   = rxdIn[1]; // (R5)
    assign chainIn[`PNCT_POS_RXD0]     = rxdIn[0]; // (R5)
    assign chainIn[`PNCT_POS_RXCTL]    = rxCtlIn; // (R5)
    assign chainIn[`PNCT_POS_RXC]      = rxcIn; // (R5)
    assign chainIn[`PNCT_POS_INT]      = intIn; // (R5)
    assign chainIn[`PNCT_POS_MDC]      = mdcIn; // (R5)
    assign chainIn[`PNCT_POS_MDIO]     = mdioIn; // (R5)

    // twenty stage chain with final inversion
    pnct_nand_chain u_chain (
        .chainIn  (chainIn),
        .chainOut (chainOut)
    );

    assign testMode         = testMode_ff;
    assign refClockTestOut  = testMode_ff ? chainOut : funcRefClock; // (R7)
    assign refClockTestOe_n = ~clkOutEn_ff; // (R8)

    // chain pins float in test, functional drive otherwise (R9)
    // status lights
    assign statusLightOe_n[4] = oeSel(testMode_ff, funcStatusLightOe_n[4]);
    assign statusLightOe_n[3] = oeSel(testMode_ff, funcStatusLightOe_n[3]);
    assign statusLightOe_n[2] = oeSel(testMode_ff, funcStatusLightOe_n[2]);
    assign statusLightOe_n[1] = oeSel(testMode_ff, funcStatusLightOe_n[1]);
    assign statusLightOe_n[0] = oeSel(testMode_ff, funcStatusLightOe_n[0]);

    // receive data
    assign rxdOe_n[3] = oeSel(testMode_ff, `PNCT_FUNC_DRIVE);
    assign rxdOe_n[2] = oeSel(testMode_ff, `PNCT_FUNC_DRIVE);
    assign rxdOe_n[1] = oeSel(testMode_ff, `PNCT_FUNC_DRIVE);
    assign rxdOe_n[0] = oeSel(testMode_ff, `PNCT_FUNC_DRIVE);

    // receive control and clock
    assign rxCtlOe_n  = oeSel(testMode_ff, `PNCT_FUNC_DRIVE);
    assign rxcOe_n    = oeSel(testMode_ff, `PNCT_FUNC_DRIVE);

    // interrupt and management data
    assign intOe_n    = oeSel(testMode_ff, funcIntOe_n);
    assign mdioOe_n   = oeSel(testMode_ff, funcMdioOe_n);

    // functional pin data passes straight through
    assign statusLightOut[4] = funcStatusLightOut[4];
    assign statusLightOut[3] = funcStatusLightOut[3];
    assign statusLightOut[2] = funcStatusLightOut[2];
    assign statusLightOut[1] = funcStatusLightOut[1];
    assign statusLightOut[0] = funcStatusLightOut[0];

    // receive data and control
    assign rxdOut[3] = funcRxdOut[3];
    assign rxdOut[2] = funcRxdOut[2];
    assign rxdOut[1] = funcRxdOut[1];
    assign rxdOut[0] = funcRxdOut[0];
    assign rxCtlOut  = funcRxCtlOut;
    assign rxcOut    = funcRxcOut;

    // interrupt and management data
    assign intOut    = funcIntOut;
    assign mdioOut   = funcMdioOut;
endmodule // pnct_pin_nand_chain_test
`default_nettype wire
